// *** shared/wwd_pkg.sv ***
// Constants, field layout and state type of the windowed watchdog timer.
package wwd_pkg;
  // -----------------------------------------------------------------
  // Watchdog configuration register layout
  // -----------------------------------------------------------------
  localparam int          FORCE_EN_BIT   = 7;
  localparam int          WIN_DIS_BIT    = 6;
  localparam int          PRE_SEL_BIT    = 4;
  localparam int          POST_MSB       = 3;
  localparam int          POST_LSB       = 0;
  localparam logic [7:0]  CFG_RESET      = 8'hdf;  // Unprogrammed bits read as one.
  localparam logic [7:0]  CFG_IMPL_MASK  = 8'hdf;  // Bit 5 is unimplemented.
  // -----------------------------------------------------------------
  // Reset control register bit positions
  // -----------------------------------------------------------------
  localparam int          RST_CTL_SW_EN_BIT = 5;
  localparam int          RST_CTL_FLAG_BIT  = 4;
  localparam int          RST_CTL_SLEEP_BIT = 3;
  localparam int          RST_CTL_IDLE_BIT  = 2;
  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int          RC_NOM_HZ      = 32000;
  localparam int          PRE_DIV_SHORT  = 32;
  localparam int          PRE_DIV_LONG   = 128;
  localparam int          BASE_SHORT_US  = 1000;
  localparam int          BASE_LONG_US   = 4000;
  localparam int          CNT_W          = 23;
  localparam logic [22:0] CNT_ZERO       = 23'h000000;
  // Power-save state of the device.
  typedef enum logic [1:0] {WWD_RUN, WWD_SLEEP, WWD_IDLE} wwd_mode_t;
endpackage

// *** rtl/wwd_low_power_rc_clock_sync.sv ***
// Synchroniser and rising-edge detector for the low-power RC clock pin.
`timescale 1ns/1ps
module wwd_rc_sync (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic low_power_rc_clock,
  output logic      rc_rise
);
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;

  // Two flops guard against metastability; the edge is taken after them.
  // The flops reset high, so a pin that is already high at release gives no false edge.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
      rc_rise <= 1'b0;
    end
    else
    begin
      sync1_r <= low_power_rc_clock;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      rc_rise <= sync2_r & ~sync3_r;
    end
  end
endmodule // wwd_rc_sync

// *** rtl/wwd_watchdog.sv ***
// Windowed watchdog timer with prescaler, postscaler and power-save wake.
`timescale 1ns/1ps
module wwd_watchdog (
  input  wire logic        clock,
  input  wire logic        rst_n,              // Power-on reset.
  input  wire logic        low_power_rc_clock, // RC oscillator pin.
  input  wire logic        sys_reset,          // Any other device reset.
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_wdata,
  input  wire logic        rst_ctl_wr,
  input  wire logic [7:0]  rst_ctl_wdata,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        power_save_instruction,
  input  wire logic        power_save_idle,    // Selects idle over sleep.
  input  wire logic        power_save_exit,    // Wake by another source.
  input  wire logic        clock_switch_done,
  output logic [7:0]       cfg_rdata,
  output logic [7:0]       rst_ctl_rdata,
  output logic             cfg_locked,
  output logic             low_power_rc_enable,
  output logic             wdt_running,
  output logic             wdt_reset,
  output logic             wdt_wake
);
  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic                 rc_rise;
  logic [7:0]           cfg_r;
  logic                 sw_en_r;
  logic                 flag_r;
  logic                 sleep_st_r;
  logic                 idle_st_r;
  logic [22:0]          cnt_r;
  logic [22:0]          cnt_nxt;
  wwd_pkg::wwd_mode_t   mode_r;
  logic                 dev_reset;
  logic                 enabled;
  logic [22:0]          period;
  logic                 timeout;
  logic                 early_clear;
  logic                 run_clear;

  // Total count in RC edges: prescale times a power-of-two postscale.
  function automatic logic [22:0] wwd_period(input logic pre, input logic [3:0] post);
    logic [22:0] base;
    base = pre ? 23'(wwd_pkg::PRE_DIV_LONG) : 23'(wwd_pkg::PRE_DIV_SHORT);
    return base << post;
  endfunction

  wwd_rc_sync i_wwd_rc_sync (
    .clock              (clock),
    .rst_n              (rst_n),
    .low_power_rc_clock (low_power_rc_clock),
    .rc_rise            (rc_rise)
  );

  // -----------------------------------------------------------------
  // Derived control
  // -----------------------------------------------------------------
  // A watchdog reset acts back on this block like any other device reset.
  assign dev_reset = sys_reset | wdt_reset;
  assign enabled   = cfg_r[wwd_pkg::FORCE_EN_BIT] | sw_en_r;
  assign low_power_rc_enable = enabled;
  assign wdt_running         = enabled;
  assign period    = wwd_period(cfg_r[wwd_pkg::PRE_SEL_BIT],
                                cfg_r[wwd_pkg::POST_MSB:wwd_pkg::POST_LSB]);
  assign timeout   = enabled & rc_rise & (cnt_r == period - 23'h000001);
  assign run_clear = watchdog_clear_instruction & (mode_r == wwd_pkg::WWD_RUN);
  assign early_clear = run_clear & enabled & ~cfg_r[wwd_pkg::WIN_DIS_BIT]
                     & (cnt_r < period - (period >> 2));
  assign cfg_rdata     = cfg_r & wwd_pkg::CFG_IMPL_MASK;
  assign rst_ctl_rdata = {2'h0, sw_en_r, flag_r, sleep_st_r, idle_st_r, 2'h0};

  // -----------------------------------------------------------------
  // Configuration register
  // -----------------------------------------------------------------
  // write once per power cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_r      <= wwd_pkg::CFG_RESET;
      cfg_locked <= 1'b0;
    end
    else if (cfg_wr && !cfg_locked)
    begin
      cfg_r      <= cfg_wdata & wwd_pkg::CFG_IMPL_MASK;
      cfg_locked <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Software enable bit
  // -----------------------------------------------------------------
  // cleared on device reset
  always_ff @(posedge clock)
  begin
    if (!rst_n || dev_reset)
      sw_en_r <= 1'b0;
    else if (rst_ctl_wr)
      sw_en_r <= rst_ctl_wdata[wwd_pkg::RST_CTL_SW_EN_BIT];
  end

  // -----------------------------------------------------------------
  // Sticky timeout flag; a new timeout beats a same-cycle clear.
  // -----------------------------------------------------------------
  // sticky flag
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      flag_r <= 1'b0;
    else if (timeout)
      flag_r <= 1'b1;
    else if (rst_ctl_wr && !rst_ctl_wdata[wwd_pkg::RST_CTL_FLAG_BIT])
      flag_r <= 1'b0;
  end

  // -----------------------------------------------------------------
  // Sleep and idle status: set on entry, left for software to clear.
  // -----------------------------------------------------------------
  // software clears status
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      sleep_st_r <= 1'b0;
      idle_st_r  <= 1'b0;
    end
    else
    begin
      if (power_save_instruction && mode_r == wwd_pkg::WWD_RUN && !power_save_idle)
        sleep_st_r <= 1'b1;
      else if (rst_ctl_wr && !rst_ctl_wdata[wwd_pkg::RST_CTL_SLEEP_BIT])
        sleep_st_r <= 1'b0;
      if (power_save_instruction && mode_r == wwd_pkg::WWD_RUN && power_save_idle)
        idle_st_r <= 1'b1;
      else if (rst_ctl_wr && !rst_ctl_wdata[wwd_pkg::RST_CTL_IDLE_BIT])
        idle_st_r <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Power-save mode tracking
  // -----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (!rst_n || dev_reset)
      mode_r <= wwd_pkg::WWD_RUN;
    else
    begin
      case (mode_r)
        wwd_pkg::WWD_RUN:
          if (power_save_instruction)
            mode_r <= power_save_idle ? wwd_pkg::WWD_IDLE : wwd_pkg::WWD_SLEEP;
        wwd_pkg::WWD_SLEEP,
        wwd_pkg::WWD_IDLE:
          if (timeout || power_save_exit)
            mode_r <= wwd_pkg::WWD_RUN;
        default:
          mode_r <= wwd_pkg::WWD_RUN;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Combined prescaler and postscaler count
  // -----------------------------------------------------------------
  // One counter serves both stages, since both always clear together.
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!enabled || timeout)
      cnt_nxt = wwd_pkg::CNT_ZERO;
    else if (rc_rise)
      cnt_nxt = cnt_r + 23'h000001;
    if (dev_reset || clock_switch_done || run_clear
        || (power_save_instruction && mode_r == wwd_pkg::WWD_RUN)
        || (power_save_exit && mode_r != wwd_pkg::WWD_RUN))
      cnt_nxt = wwd_pkg::CNT_ZERO;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      cnt_r <= wwd_pkg::CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  // -----------------------------------------------------------------
  // Reset and wake pulses
  // -----------------------------------------------------------------
  // reset or wake
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wdt_reset <= 1'b0;
      wdt_wake  <= 1'b0;
    end
    else
    begin
      wdt_reset <= ~wdt_reset & ((timeout && mode_r == wwd_pkg::WWD_RUN) || early_clear);
      wdt_wake  <= timeout && mode_r != wwd_pkg::WWD_RUN;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  property p_force_on;
    @(posedge clock) disable iff (!rst_n)
      cfg_r[wwd_pkg::FORCE_EN_BIT] |-> low_power_rc_enable && wdt_running;
  endproperty
  a_force_on: assert property (p_force_on) else $error("forced watchdog not running");

  property p_sw_gate;
    @(posedge clock) disable iff (!rst_n)
      !cfg_r[wwd_pkg::FORCE_EN_BIT] && !sw_en_r |-> !wdt_running ##1 cnt_r == 23'h000000;
  endproperty
  a_sw_gate: assert property (p_sw_gate) else $error("disabled watchdog counting");

  property p_reset_clears_en;
    @(posedge clock) disable iff (!rst_n)
      sys_reset |=> !sw_en_r;
  endproperty
  a_reset_clears_en: assert property (p_reset_clears_en) else $error("enable survived reset");

  property p_run_timeout;
    @(posedge clock) disable iff (!rst_n)
      timeout && mode_r == wwd_pkg::WWD_RUN && !wdt_reset |=> wdt_reset && flag_r ##1 !wdt_reset;
  endproperty
  a_run_timeout: assert property (p_run_timeout) else $error("timeout gave no reset");

  property p_early_clear;
    @(posedge clock) disable iff (!rst_n)
      run_clear && enabled && !cfg_r[wwd_pkg::WIN_DIS_BIT] && !wdt_reset
      && (cnt_r < period - (period >> 2)) |=> wdt_reset;
  endproperty
  a_early_clear: assert property (p_early_clear) else $error("early clear not punished");

  property p_no_window;
    @(posedge clock) disable iff (!rst_n)
      run_clear && cfg_r[wwd_pkg::WIN_DIS_BIT] && !timeout |=> !wdt_reset && cnt_r == 23'h000000;
  endproperty
  a_no_window: assert property (p_no_window) else $error("clear misbehaved out of window");

  property p_sleep_wake;
    @(posedge clock) disable iff (!rst_n)
      timeout && mode_r != wwd_pkg::WWD_RUN |=> wdt_wake && !wdt_reset && mode_r == wwd_pkg::WWD_RUN;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep timeout did not wake");

  property p_flag_sticky;
    @(posedge clock) disable iff (!rst_n)
      flag_r && !rst_ctl_wr |=> flag_r;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

  property p_cfg_once;
    @(posedge clock) disable iff (!rst_n)
      cfg_locked |=> $stable(cfg_r) && cfg_locked;
  endproperty
  a_cfg_once: assert property (p_cfg_once) else $error("config changed after lock");

  property p_psave_zero;
    @(posedge clock) disable iff (!rst_n)
      power_save_instruction && mode_r == wwd_pkg::WWD_RUN |=> cnt_r == 23'h000000;
  endproperty
  a_psave_zero: assert property (p_psave_zero) else $error("power save kept count");

  property p_prescale;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |-> period == (cfg_r[wwd_pkg::PRE_SEL_BIT] ? 23'h000080 : 23'h000020)
                         << cfg_r[wwd_pkg::POST_MSB:wwd_pkg::POST_LSB];
  endproperty
  a_prescale: assert property (p_prescale) else $error("wrong period");

  c_run_reset:  cover property (@(posedge clock) disable iff (!rst_n) wdt_reset && !early_clear);
  c_early:      cover property (@(posedge clock) disable iff (!rst_n) early_clear);
  c_wake:       cover property (@(posedge clock) disable iff (!rst_n) wdt_wake);
endmodule // wwd_watchdog

// *** verif/wwd_watchdog_tb.sv ***
// Self-checking testbench for the windowed watchdog timer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end
module wwd_watchdog_tb;
  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic       clock;
  logic       rst_n;
  logic       low_power_rc_clock;
  logic       sys_reset;
  logic       cfg_wr;
  logic [7:0] cfg_wdata;
  logic       rst_ctl_wr;
  logic [7:0] rst_ctl_wdata;
  logic       watchdog_clear_instruction;
  logic       power_save_instruction;
  logic       power_save_idle;
  logic       power_save_exit;
  logic       clock_switch_done;
  logic [7:0] cfg_rdata;
  logic [7:0] rst_ctl_rdata;
  logic       cfg_locked;
  logic       low_power_rc_enable;
  logic       wdt_running;
  logic       wdt_reset;
  logic       wdt_wake;
  int         failures;
  int         checks;
  int         rises;
  int         nres;
  int         n;
  int         r0;
  int         k0;

  wwd_watchdog i_wwd_watchdog (.clock(clock), .rst_n(rst_n),
    .low_power_rc_clock(low_power_rc_clock), .sys_reset(sys_reset), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .rst_ctl_wr(rst_ctl_wr), .rst_ctl_wdata(rst_ctl_wdata),
    .watchdog_clear_instruction(watchdog_clear_instruction),
    .power_save_instruction(power_save_instruction), .power_save_idle(power_save_idle),
    .power_save_exit(power_save_exit), .clock_switch_done(clock_switch_done),
    .cfg_rdata(cfg_rdata), .rst_ctl_rdata(rst_ctl_rdata), .cfg_locked(cfg_locked),
    .low_power_rc_enable(low_power_rc_enable), .wdt_running(wdt_running),
    .wdt_reset(wdt_reset), .wdt_wake(wdt_wake));

  // System clock at 10 MHz.
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // RC pin toggles every 4 clocks, slow enough for the two-flop synchroniser.
  initial
  begin
    low_power_rc_clock = 1'b0;
    forever
    begin
      repeat (4) @(posedge clock);
      #10 low_power_rc_clock = ~low_power_rc_clock;
    end
  end

  // Count RC rises and watchdog resets, sampled away from the active edge.
  always @(posedge low_power_rc_clock) rises++;
  always @(negedge clock) if (wdt_reset === 1'b1) nres++;

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c)
    begin
      @(posedge clock);
      #10;
    end
  endtask

  task automatic por();
    rst_n = 1'b0;
    tick(8);
    rst_n = 1'b1;
    tick(1);
  endtask

  task automatic cfg_write(input logic [7:0] d);
    cfg_wr    = 1'b1;
    cfg_wdata = d;
    tick(1);
    cfg_wr    = 1'b0;
  endtask

  task automatic rst_ctl_write(input logic [7:0] d);
    rst_ctl_wr    = 1'b1;
    rst_ctl_wdata = d;
    tick(1);
    rst_ctl_wr    = 1'b0;
  endtask

  // Pulse source select: 0 clear, 1 clock switch, 2 power save, 3 exit, 4 sys reset.
  task automatic set_src(input int k, input logic v);
    case (k)
      0: watchdog_clear_instruction = v;
      1: clock_switch_done = v;
      2: power_save_instruction = v;
      3: power_save_exit = v;
      default: sys_reset = v;
    endcase
  endtask

  // One-cycle pulse; only the raised source is lowered, so back-to-back pulses
  // never assign one signal twice in a time step.
  task automatic strobe(input int k);
    set_src(k, 1'b1);
    tick(1);
    set_src(k, 1'b0);
  endtask

  // Bounded wait for a reset pulse, or a wake pulse when wk is set.
  task automatic wait_evt(input bit wk, input int lim);
    n = 0;
    while ((wk ? wdt_wake : wdt_reset) !== 1'b1 && n < lim)
    begin
      tick(1);
      n++;
    end
  endtask

  // Timeout after a mid-period clear of kind k must take p RC edges.
  task automatic meas(input logic [7:0] cfg, input int p, input int k);
    por();
    cfg_write(cfg);
    rst_ctl_write(8'h20);
    tick(p * 4);
    r0 = rises;
    strobe(k);
    wait_evt(1'b0, p * 8 + 40);
    `CHK("period", 1'b1, (rises - r0) inside {[p - 1:p + 1]})
    `CHK("flag", 1'b1, rst_ctl_rdata[4])
    strobe(4);
    `CHK("ctl_after_reset", 8'h10, rst_ctl_rdata)
    rst_ctl_write(8'h00);
    `CHK("flag_cleared", 8'h00, rst_ctl_rdata)
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog against a hang, well beyond the expected run length.
  initial
  begin
    repeat (40000) @(posedge clock);
    failures++;
    final_report();
  end

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial
  begin
    {sys_reset, cfg_wr, rst_ctl_wr, watchdog_clear_instruction} = 4'h0;
    {power_save_instruction, power_save_idle, power_save_exit, clock_switch_done} = 4'h0;
    cfg_wdata     = 8'h00;
    rst_ctl_wdata = 8'h00;
    failures = 0;
    checks = 0;
    rises = 0;
    nres = 0;
    por();
    `CHK("cfg_reset", 8'hdf, cfg_rdata)
    `CHK("ctl_reset", 8'h00, rst_ctl_rdata)
    `CHK("run_forced", 1'b1, wdt_running)
    cfg_write(8'h40);
    tick(1);
    cfg_write(8'hff);
    `CHK("cfg_once", 8'h40, cfg_rdata)
    `CHK("locked", 1'b1, cfg_locked)
    `CHK("run_off", 1'b0, wdt_running)
    rst_ctl_write(8'h20);
    `CHK("run_sw", 1'b1, wdt_running)
    `CHK("rc_on", 1'b1, low_power_rc_enable)
    por();
    cfg_write(8'hc0);
    rst_ctl_write(8'h00);
    `CHK("force_keeps", 1'b1, wdt_running)
    `CHK("force_rc", 1'b1, low_power_rc_enable)
    meas(8'h40, 32, 0);
    meas(8'h50, 128, 1);
    meas(8'h41, 64, 0);
    por();
    cfg_write(8'h00);
    rst_ctl_write(8'h20);
    tick(16);
    strobe(0);
    wait_evt(1'b0, 3);
    `CHK("early_clear", 1'b1, wdt_reset)
    strobe(4);
    rst_ctl_write(8'h20);
    tick(224);
    strobe(0);
    wait_evt(1'b0, 4);
    `CHK("late_clear", 1'b0, wdt_reset)
    for (int i = 0; i < 2; i++)
    begin
      por();
      cfg_write(8'h40);
      rst_ctl_write(8'h20);
      power_save_idle = i[0];
      strobe(2);
      `CHK("ps_status", i ? 8'h24 : 8'h28, rst_ctl_rdata)
      k0 = nres;
      wait_evt(1'b1, 300);
      `CHK("wake", 1'b1, wdt_wake)
      `CHK("no_reset", 0, nres - k0)
      tick(1);
      `CHK("status_kept", i ? 8'h34 : 8'h38, rst_ctl_rdata)
      // Software clears the status and flag bits after the wake, keeping the enable.
      rst_ctl_write(8'h20);
      `CHK("status_cleared", 8'h20, rst_ctl_rdata)
      strobe(2);
      tick(100);
      r0 = rises;
      strobe(3);
      wait_evt(1'b0, 300);
      `CHK("exit_period", 1'b1, (rises - r0) inside {[31:33]})
    end
    final_report();
  end
endmodule // wwd_watchdog_tb
